// ==== pkg/mrc_pkg.sv ====
// Shared constants of the cluster reset and clock-enable control
package mrc_pkg;
   localparam int CORES = 4;
   localparam int BUS_W = 32;
   localparam int RATIO_W = 4;
   localparam int RST_BITS = 3 * CORES + 2;
   localparam int SIG_BITS = 7 * CORES;
   localparam logic [RATIO_W-1:0] BUS_RATIO_RST = 4'h1;
   localparam logic [RATIO_W-1:0] DBG_RATIO_RST = 4'h1;
   localparam logic [BUS_W-1:0] DATA_RST = 32'h00000000;
   localparam logic [CORES-1:0] IRQ_IDLE = 4'hf;
   localparam logic [CORES-1:0] EN_IDLE = 4'h0;
   localparam logic [SIG_BITS-1:0] SIG_RST = 28'h000ffff;
endpackage : mrc_pkg

// ==== pkg/mrc_link_if.sv ====
// Link between the system end and the processor cluster end
`timescale 1ns/10ps
`default_nettype none
interface mrc_link_if;
   logic [3:0] corePowerOnReset_n;
   logic [3:0] corePrimaryReset_n;
   logic [3:0] coreDebugReset_n;
   logic sharedCacheReset_n;
   logic memorySelftestReset_n;
   logic [3:0] normalInterrupt_n;
   logic [3:0] fastInterrupt_n;
   logic [3:0] virtualNormalInterrupt_n;
   logic [3:0] virtualFastInterrupt_n;
   logic [3:0] invasiveDebugEnable;
   logic [3:0] secureInvasiveDebugEnable;
   logic [3:0] externalDebugRequest;
   logic [3:0] skipCacheInvalidate;
   logic busMasterClockEnable;
   logic debugBusClockEnable;
   logic [31:0] busData;
   logic [31:0] debugData;
   modport dev (
      input corePowerOnReset_n, corePrimaryReset_n, coreDebugReset_n,
      input sharedCacheReset_n, memorySelftestReset_n,
      input normalInterrupt_n, fastInterrupt_n,
      input virtualNormalInterrupt_n, virtualFastInterrupt_n,
      input invasiveDebugEnable, secureInvasiveDebugEnable,
      input externalDebugRequest, skipCacheInvalidate,
      input busMasterClockEnable, debugBusClockEnable, busData, debugData
   );
   modport sys (
      output corePowerOnReset_n, corePrimaryReset_n, coreDebugReset_n,
      output sharedCacheReset_n, memorySelftestReset_n,
      output normalInterrupt_n, fastInterrupt_n,
      output virtualNormalInterrupt_n, virtualFastInterrupt_n,
      output invasiveDebugEnable, secureInvasiveDebugEnable,
      output externalDebugRequest, skipCacheInvalidate,
      output busMasterClockEnable, debugBusClockEnable, busData, debugData
   );
endinterface : mrc_link_if
`default_nettype wire

// ==== logic/mrc_sync.sv ====
// Two-stage synchroniser with asynchronous reset to a constant
`timescale 1ns/10ps
`default_nettype none
module mrc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta <= RST;
         q <= RST;
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : mrc_sync
`default_nettype wire

// ==== logic/mrc_device.sv ====
// Cluster end: reset synchronising, domain decode and enable sampling
// Overview of operation
// - Synchronise resets, interrupts, debug inputs to core clock
// - System drives other inputs synchronous to core
// - Bus runs integer ratio set by enable
// - Enable asserted cycle before each bus edge
// - Ratio changes live; sample only when enabled
// - Debug bus qualified by its own enable
// - Power-on reset clears core and core debug
// - Primary reset clears core, keeps debug
// - Debug reset clears debug logic only
// - Per-core reset bits; shared bits fan out
// - Self-test reset resets all, flags test entry
// - Shared-cache reset clears cache and coherency unit
// - Resets asynchronous, active low, own domain
// - All power-on and shared low: everything reset, unless all primary low and all debug high
// - Power-on, primary low, debug high keeps debug
// - Software reset keeps debug and shared cache
// - Software plus shared reset keeps debug alive
// - Single core primary reset keeps its debug
// - Debug reset alone holds only debug
// - All resets high: nothing held
// - System asserts power-on for core reset
// - Single power-on reset holds core and debug
// - Skip flag at release suppresses cache invalidate
`timescale 1ns/10ps
`default_nettype none
module mrc_device (
   // Link clock
   input wire logic coreClk,
   // Link to system end
   mrc_link_if.dev link,
   // Decoded domain resets
   output logic [3:0] coreLogicReset_n,
   output logic [3:0] coreDebugLogicReset_n,
   output logic [3:0] debugDomainReset_n,
   output logic sharedCacheLogicReset_n,
   output logic selftestPrepare,
   // Synchronised interrupt and debug signals
   output logic [3:0] normalIrq_n,
   output logic [3:0] fastIrq_n,
   output logic [3:0] virtualNormalIrq_n,
   output logic [3:0] virtualFastIrq_n,
   output logic [3:0] debugEnable,
   output logic [3:0] secureDebugEnable,
   output logic [3:0] debugRequest,
   // Cache invalidate at reset release
   output logic [3:0] invalidateStart,
   // Bus sampling
   output logic [31:0] busSample,
   output logic busSampleValid,
   output logic [3:0] busRatio,
   // Debug bus sampling
   output logic [31:0] debugSample,
   output logic debugSampleValid,
   output logic [3:0] debugRatio
);
   typedef struct packed {
      logic [3:0] runSeen;
      logic [3:0] invalidate;
      logic [31:0] busSample;
      logic busValid;
      logic [3:0] busGap;
      logic [3:0] busRatio;
      logic [31:0] dbgSample;
      logic dbgValid;
      logic [3:0] dbgGap;
      logic [3:0] dbgRatio;
   } mrc_dev_state_t;

   // Gap counter and measured ratio update on one enable
   function automatic logic [7:0] mrc_tick(
      input logic en,
      input logic [3:0] gap,
      input logic [3:0] ratio
   );
      logic [7:0] res;
      res = {gap, ratio};
      if (en)
      begin
         res = {4'h0, (gap == 4'hf) ? gap : 4'(gap + 4'h1)};
      end
      else if (gap != 4'hf)
      begin
         res = {4'(gap + 4'h1), ratio};
      end
      return res;
   endfunction : mrc_tick

   logic [mrc_pkg::RST_BITS-1:0] rawRst;
   logic [mrc_pkg::RST_BITS-1:0] syncRst;
   logic [mrc_pkg::SIG_BITS-1:0] rawSig;
   logic [mrc_pkg::SIG_BITS-1:0] syncSig;
   logic [3:0] poSync;
   logic [3:0] priSync;
   logic [3:0] dbgSync;
   logic l2Sync;
   logic testSync;
   logic allOff;
   mrc_dev_state_t s;
   mrc_dev_state_t next_s;

   // Reset bits, one per core per kind, shared bits once
   assign rawRst = {link.memorySelftestReset_n, link.sharedCacheReset_n,
                    link.coreDebugReset_n, link.corePrimaryReset_n,
                    link.corePowerOnReset_n};

   // Immediate assertion, two-edge release per reset bit
   generate
      for (genvar i = 0; i < mrc_pkg::RST_BITS; i++)
      begin : g_rst
         mrc_sync #(
            .W(1),
            .RST(1'b0)
         ) u_rst (
            .clk(coreClk),
            .arst_n(rawRst[i]),
            .d(1'b1),
            .q(syncRst[i])
         );
      end
   endgenerate

   assign poSync = syncRst[3:0];
   assign priSync = syncRst[7:4];
   assign dbgSync = syncRst[11:8];
   assign l2Sync = syncRst[12];
   assign testSync = syncRst[13];

   // Interrupt and debug inputs into the core clock
   assign rawSig = {link.externalDebugRequest,
                    link.secureInvasiveDebugEnable,
                    link.invasiveDebugEnable,
                    link.virtualFastInterrupt_n,
                    link.virtualNormalInterrupt_n,
                    link.fastInterrupt_n,
                    link.normalInterrupt_n};

   mrc_sync #(
      .W(mrc_pkg::SIG_BITS),
      .RST(mrc_pkg::SIG_RST)
   ) u_sig (
      .clk(coreClk),
      .arst_n(testSync),
      .d(rawSig),
      .q(syncSig)
   );

   assign normalIrq_n = syncSig[3:0];
   assign fastIrq_n = syncSig[7:4];
   assign virtualNormalIrq_n = syncSig[11:8];
   assign virtualFastIrq_n = syncSig[15:12];
   assign debugEnable = syncSig[19:16];
   assign secureDebugEnable = syncSig[23:20];
   assign debugRequest = syncSig[27:24];

   // Full power-on of cluster and shared cache
   assign allOff = (poSync == 4'h0) && !l2Sync
                   && !((priSync == 4'h0) && (dbgSync == 4'hf));

   // Domain decode
   assign coreLogicReset_n = poSync & priSync & {4{testSync}};
   assign coreDebugLogicReset_n = poSync & dbgSync & {4{testSync}}
                                  & {4{!allOff}};
   assign debugDomainReset_n = dbgSync & {4{testSync}}
                               & {4{!allOff}};
   assign sharedCacheLogicReset_n = l2Sync & testSync;
   assign selftestPrepare = !testSync;

   assign invalidateStart = s.invalidate;
   assign busSample = s.busSample;
   assign busSampleValid = s.busValid;
   assign busRatio = s.busRatio;
   assign debugSample = s.dbgSample;
   assign debugSampleValid = s.dbgValid;
   assign debugRatio = s.dbgRatio;

   always_comb
   begin
      next_s = s;
      for (int n = 0; n < mrc_pkg::CORES; n++)
      begin
         next_s.runSeen[n] = coreLogicReset_n[n];
         next_s.invalidate[n] = coreLogicReset_n[n] && !s.runSeen[n]
                                && !link.skipCacheInvalidate[n];
      end
      // Bus beats taken only on enabled cycles
      next_s.busValid = link.busMasterClockEnable;
      if (link.busMasterClockEnable)
      begin
         next_s.busSample = link.busData;
      end
      {next_s.busGap, next_s.busRatio} =
         mrc_tick(link.busMasterClockEnable, s.busGap, s.busRatio);
      // Debug bus qualified by its own enable
      next_s.dbgValid = link.debugBusClockEnable;
      if (link.debugBusClockEnable)
      begin
         next_s.dbgSample = link.debugData;
      end
      {next_s.dbgGap, next_s.dbgRatio} =
         mrc_tick(link.debugBusClockEnable, s.dbgGap, s.dbgRatio);
   end

   always_ff @(posedge coreClk or negedge testSync)
   begin
      if (!testSync)
      begin
         s.runSeen <= 4'h0;
         s.invalidate <= 4'h0;
         s.busSample <= mrc_pkg::DATA_RST;
         s.busValid <= 1'b0;
         s.busGap <= 4'h0;
         s.busRatio <= mrc_pkg::BUS_RATIO_RST;
         s.dbgSample <= mrc_pkg::DATA_RST;
         s.dbgValid <= 1'b0;
         s.dbgGap <= 4'h0;
         s.dbgRatio <= mrc_pkg::DBG_RATIO_RST;
      end
      else
      begin
         s <= next_s;
      end
   end
endmodule : mrc_device
`default_nettype wire

// ==== logic/mrc_system.sv ====
// System end: reset requests, interrupt drive and bus clock enables
`timescale 1ns/10ps
`default_nettype none
module mrc_system (
   // System clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link clock
   input wire logic coreClk,
   // Link to cluster end
   mrc_link_if.sys link,
   // Reset requests, high asserts the reset
   input wire logic [3:0] powerOnReq,
   input wire logic [3:0] primaryReq,
   input wire logic [3:0] debugReq,
   input wire logic sharedReq,
   input wire logic selftestReq,
   // Interrupt and debug requests, high active
   input wire logic [3:0] normalIrqReq,
   input wire logic [3:0] fastIrqReq,
   input wire logic [3:0] virtualNormalIrqReq,
   input wire logic [3:0] virtualFastIrqReq,
   input wire logic [3:0] debugEnableReq,
   input wire logic [3:0] secureDebugEnableReq,
   input wire logic [3:0] debugRequestReq,
   input wire logic [3:0] skipInvalidateReq,
   // Ratio command
   input wire logic ratioLoad,
   input wire logic [3:0] busRatioReq,
   input wire logic [3:0] debugRatioReq,
   output logic ratioBusy
);
   typedef struct packed {
      logic [3:0] po;
      logic [3:0] pri;
      logic [3:0] dbg;
      logic l2;
      logic test;
      logic [27:0] sig;
      logic [3:0] busHold;
      logic [3:0] dbgHold;
      logic reqTog;
   } mrc_sys_state_t;

   typedef struct packed {
      logic ackTog;
      logic [3:0] busRatio;
      logic [3:0] busPend;
      logic [3:0] busCnt;
      logic [3:0] dbgRatio;
      logic [3:0] dbgPend;
      logic [3:0] dbgCnt;
      logic [31:0] busData;
      logic [31:0] dbgData;
   } mrc_lnk_state_t;

   // Enable on the last core cycle of each bus period
   function automatic logic mrc_div(
      input logic [3:0] cnt,
      input logic [3:0] ratio
   );
      logic [3:0] last;
      last = (ratio == 4'h0) ? 4'h0 : 4'(ratio - 4'h1);
      return cnt >= last;
   endfunction : mrc_div

   mrc_sys_state_t s;
   mrc_sys_state_t next_s;
   mrc_lnk_state_t k;
   mrc_lnk_state_t next_k;
   logic coreRst_n;
   logic reqSync;
   logic ackSync;
   logic [3:0] skipSync;
   logic busEn;
   logic invasive_debug_enable;

   mrc_sync #(.W(1), .RST(1'b0)) u_rst (
      .clk(coreClk),
      .arst_n(resetn),
      .d(1'b1),
      .q(coreRst_n)
   );
   mrc_sync #(.W(1), .RST(1'b0)) u_req (
      .clk(coreClk),
      .arst_n(coreRst_n),
      .d(s.reqTog),
      .q(reqSync)
   );
   mrc_sync #(.W(1), .RST(1'b0)) u_ack (
      .clk(clk),
      .arst_n(resetn),
      .d(k.ackTog),
      .q(ackSync)
   );
   // Skip flag must be synchronous to the core clock
   mrc_sync #(.W(4), .RST(4'h0)) u_skip (
      .clk(coreClk),
      .arst_n(coreRst_n),
      .d(skipInvalidateReq),
      .q(skipSync)
   );

   assign ratioBusy = s.reqTog != ackSync;
   assign busEn = mrc_div(k.busCnt, k.busRatio);
   assign invasive_debug_enable = mrc_div(k.dbgCnt, k.dbgRatio);

   assign link.corePowerOnReset_n = s.po;
   assign link.corePrimaryReset_n = s.pri;
   assign link.coreDebugReset_n = s.dbg;
   assign link.sharedCacheReset_n = s.l2;
   assign link.memorySelftestReset_n = s.test;
   assign link.normalInterrupt_n = s.sig[3:0];
   assign link.fastInterrupt_n = s.sig[7:4];
   assign link.virtualNormalInterrupt_n = s.sig[11:8];
   assign link.virtualFastInterrupt_n = s.sig[15:12];
   assign link.invasiveDebugEnable = s.sig[19:16];
   assign link.secureInvasiveDebugEnable = s.sig[23:20];
   assign link.externalDebugRequest = s.sig[27:24];
   assign link.skipCacheInvalidate = skipSync;
   assign link.busMasterClockEnable = busEn;
   assign link.debugBusClockEnable = invasive_debug_enable;
   assign link.busData = k.busData;
   assign link.debugData = k.dbgData;

   always_comb
   begin
      next_s = s;
      next_s.po = ~(powerOnReq | primaryReq | debugReq);
      next_s.pri = ~primaryReq;
      next_s.dbg = ~debugReq;
      next_s.l2 = ~sharedReq;
      next_s.test = ~selftestReq;
      next_s.sig = {debugRequestReq, secureDebugEnableReq, debugEnableReq,
                    ~virtualFastIrqReq, ~virtualNormalIrqReq,
                    ~fastIrqReq, ~normalIrqReq};
      if (ratioLoad && !ratioBusy)
      begin
         next_s.busHold = busRatioReq;
         next_s.dbgHold = debugRatioReq;
         next_s.reqTog = !s.reqTog;
      end
   end

   always_comb
   begin
      next_k = k;
      if (reqSync != k.ackTog)
      begin
         next_k.busPend = s.busHold;
         next_k.dbgPend = s.dbgHold;
         next_k.ackTog = reqSync;
      end
      // New ratio starts at a period boundary to keep alignment
      if (busEn)
      begin
         next_k.busCnt = 4'h0;
         next_k.busRatio = k.busPend;
         next_k.busData = 32'(k.busData + 32'h1);
      end
      else
      begin
         next_k.busCnt = 4'(k.busCnt + 4'h1);
      end
      if (invasive_debug_enable)
      begin
         next_k.dbgCnt = 4'h0;
         next_k.dbgRatio = k.dbgPend;
         next_k.dbgData = 32'(k.dbgData + 32'h1);
      end
      else
      begin
         next_k.dbgCnt = 4'(k.dbgCnt + 4'h1);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s.po <= 4'h0;
         s.pri <= 4'h0;
         s.dbg <= 4'h0;
         s.l2 <= 1'b0;
         s.test <= 1'b0;
         s.sig <= mrc_pkg::SIG_RST;
         s.busHold <= mrc_pkg::BUS_RATIO_RST;
         s.dbgHold <= mrc_pkg::DBG_RATIO_RST;
         s.reqTog <= 1'b0;
      end
      else
      begin
         s <= next_s;
      end
   end

   always_ff @(posedge coreClk or negedge coreRst_n)
   begin
      if (!coreRst_n)
      begin
         k.ackTog <= 1'b0;
         k.busRatio <= mrc_pkg::BUS_RATIO_RST;
         k.busPend <= mrc_pkg::BUS_RATIO_RST;
         k.busCnt <= 4'h0;
         k.dbgRatio <= mrc_pkg::DBG_RATIO_RST;
         k.dbgPend <= mrc_pkg::DBG_RATIO_RST;
         k.dbgCnt <= 4'h0;
         k.busData <= mrc_pkg::DATA_RST;
         k.dbgData <= mrc_pkg::DATA_RST;
      end
      else
      begin
         k <= next_k;
      end
   end
endmodule : mrc_system
`default_nettype wire

// ==== verification/mrc_link_asserts.sv ====
// Checker on the link between the system end and the cluster end
`timescale 1ns/10ps
`default_nettype none
module mrc_link_asserts (
   // Clocks and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic coreClk,
   // Link signals
   input wire logic [3:0] corePowerOnReset_n,
   input wire logic [3:0] corePrimaryReset_n,
   input wire logic [3:0] coreDebugReset_n,
   input wire logic sharedCacheReset_n,
   input wire logic memorySelftestReset_n,
   input wire logic [3:0] normalInterrupt_n,
   input wire logic [3:0] invasiveDebugEnable,
   input wire logic busMasterClockEnable,
   input wire logic debugBusClockEnable,
   input wire logic [31:0] busData,
   input wire logic [31:0] debugData
);
   // Core side settled after reset
   logic [2:0] upCnt;
   logic live;
   always_ff @(posedge coreClk or negedge resetn)
   begin
      if (!resetn)
         upCnt <= 3'h0;
      else if (upCnt != 3'h7)
         upCnt <= upCnt + 3'h1;
   end
   assign live = (upCnt == 3'h7);
   sequence s_busNext;
      ##[1:15] busMasterClockEnable;
   endsequence
   sequence s_dbgNext;
      ##[1:15] debugBusClockEnable;
   endsequence
   property p_busSpacing;
      @(posedge coreClk) disable iff (!resetn)
      (live && busMasterClockEnable) |-> s_busNext;
   endproperty
   a_busSpacing: assert property (p_busSpacing)
      else $error("bus enable spacing beyond fifteen cycles");
   property p_dbgSpacing;
      @(posedge coreClk) disable iff (!resetn)
      (live && debugBusClockEnable) |-> s_dbgNext;
   endproperty
   a_dbgSpacing: assert property (p_dbgSpacing)
      else $error("debug enable spacing beyond fifteen cycles");
   property p_busStep;
      @(posedge coreClk) disable iff (!resetn)
      (live && busMasterClockEnable) |=> busData == $past(busData) + 32'h1;
   endproperty
   a_busStep: assert property (p_busStep)
      else $error("bus beat missed after enable");
   property p_busHold;
      @(posedge coreClk) disable iff (!resetn)
      (live && !busMasterClockEnable) |=> $stable(busData);
   endproperty
   a_busHold: assert property (p_busHold)
      else $error("bus data moved without enable");
   property p_dbgStep;
      @(posedge coreClk) disable iff (!resetn)
      (live && debugBusClockEnable) |=> debugData == $past(debugData) + 32'h1;
   endproperty
   a_dbgStep: assert property (p_dbgStep)
      else $error("debug beat missed after enable");
   property p_dbgHold;
      @(posedge coreClk) disable iff (!resetn)
      (live && !debugBusClockEnable) |=> $stable(debugData);
   endproperty
   a_dbgHold: assert property (p_dbgHold)
      else $error("debug data moved without enable");
   property p_poCovers;
      @(posedge clk) disable iff (!resetn)
      ((~corePrimaryReset_n | ~coreDebugReset_n) & corePowerOnReset_n) == 4'h0;
   endproperty
   a_poCovers: assert property (p_poCovers)
      else $error("core reset without power-on reset");
   property p_resetLeave;
      @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> corePowerOnReset_n == 4'h0 && !sharedCacheReset_n
         && !memorySelftestReset_n;
   endproperty
   a_resetLeave: assert property (p_resetLeave)
      else $error("link resets not low during system reset");
   property p_sigIdle;
      @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> normalInterrupt_n == 4'hf && invasiveDebugEnable == 4'h0;
   endproperty
   a_sigIdle: assert property (p_sigIdle)
      else $error("interrupts not idle during system reset");
endmodule : mrc_link_asserts
`default_nettype wire

// ==== verification/multicore_reset_clock_enable_ctrl_tb_top.sv ====
// Bench joining both link ends with a reset and ratio model
`timescale 1ns/10ps
`default_nettype none
module multicore_reset_clock_enable_ctrl_tb_top;
   logic clk = 1'b0, coreClk = 1'b0, resetn = 1'b0;
   logic [3:0] powerOnReq = 4'h0, primaryReq = 4'h0, debugReq = 4'h0;
   logic sharedReq = 1'b0, selftestReq = 1'b0, ratioLoad = 1'b0;
   logic [3:0] normal_interrupt_n = 4'h0, fIrq = 4'h0, vnIrq = 4'h0, vfIrq = 4'h0;
   logic [3:0] dEn = 4'h0, sEn = 4'h0, dRq = 4'h0, skip = 4'h0;
   logic [3:0] busRatioReq = 4'h1, debugRatioReq = 4'h1;
   logic ratioBusy, sharedOut, selftestPrepare, bValid, dValid;
   logic [3:0] coreRst, coreDbgRst, dbgDomRst, invalidateStart;
   logic [3:0] oN, oF, oVn, oVf, oDe, oSe, oDr, busRatio, debugRatio;
   logic [31:0] bSample, dSample;
   logic [3:0] invQ[$];
   logic [31:0] expBus = 32'h0, expDbg = 32'h0;
   logic expBv = 1'b0, expDv = 1'b0, lastRun = 1'b0;
   logic [9:0] combos[6] = '{10'h3c2, 10'h3fe, 10'h002, 10'h001,
                             10'h0f0, 10'h3ff};
   int ratios[$] = '{3, 1, 2, 0, 15};
   integer seed = 32'h7864, nErrors = 0, nChecks = 0, cycles = 0, k;
   mrc_link_if link();
   mrc_system u_mrc_system (.clk(clk), .resetn(resetn), .coreClk(coreClk),
      .link(link), .powerOnReq(powerOnReq), .primaryReq(primaryReq),
      .debugReq(debugReq), .sharedReq(sharedReq), .selftestReq(selftestReq),
      .normalIrqReq(normal_interrupt_n), .fastIrqReq(fIrq), .virtualNormalIrqReq(vnIrq),
      .virtualFastIrqReq(vfIrq), .debugEnableReq(dEn),
      .secureDebugEnableReq(sEn), .debugRequestReq(dRq),
      .skipInvalidateReq(skip), .ratioLoad(ratioLoad),
      .busRatioReq(busRatioReq), .debugRatioReq(debugRatioReq),
      .ratioBusy(ratioBusy));
   mrc_device u_mrc_device (.coreClk(coreClk), .link(link),
      .coreLogicReset_n(coreRst), .coreDebugLogicReset_n(coreDbgRst),
      .debugDomainReset_n(dbgDomRst), .sharedCacheLogicReset_n(sharedOut),
      .selftestPrepare(selftestPrepare), .normalIrq_n(oN), .fastIrq_n(oF),
      .virtualNormalIrq_n(oVn), .virtualFastIrq_n(oVf), .debugEnable(oDe),
      .secureDebugEnable(oSe), .debugRequest(oDr),
      .invalidateStart(invalidateStart), .busSample(bSample),
      .busSampleValid(bValid), .busRatio(busRatio), .debugSample(dSample),
      .debugSampleValid(dValid), .debugRatio(debugRatio));
   mrc_link_asserts u_mrc_link_asserts (.clk(clk), .resetn(resetn),
      .coreClk(coreClk), .corePowerOnReset_n(link.corePowerOnReset_n),
      .corePrimaryReset_n(link.corePrimaryReset_n),
      .coreDebugReset_n(link.coreDebugReset_n),
      .sharedCacheReset_n(link.sharedCacheReset_n),
      .memorySelftestReset_n(link.memorySelftestReset_n),
      .normalInterrupt_n(link.normalInterrupt_n),
      .invasiveDebugEnable(link.invasiveDebugEnable),
      .busMasterClockEnable(link.busMasterClockEnable),
      .debugBusClockEnable(link.debugBusClockEnable),
      .busData(link.busData), .debugData(link.debugData));
   always #2.5 clk = ~clk;
   initial
   begin
      #3.3;
      forever #15 coreClk = ~coreClk;
   end
   always @(posedge coreClk)
   begin
      if (invalidateStart !== 4'h0)
         invQ.push_back(invalidateStart);
   end
   // Sample model, one edge behind the device registers
   always @(posedge coreClk)
   begin
      if (lastRun && selftestPrepare === 1'b0)
      begin
         chkWord(bSample, expBus);
         chkWord(dSample, expDbg);
         chkVec({3'h0, bValid}, {3'h0, expBv});
         chkVec({3'h0, dValid}, {3'h0, expDv});
      end
      lastRun = (selftestPrepare === 1'b0);
      expBv = lastRun && link.busMasterClockEnable;
      expDv = lastRun && link.debugBusClockEnable;
      if (!lastRun)
      begin
         expBus = mrc_pkg::DATA_RST;
         expDbg = mrc_pkg::DATA_RST;
      end
      if (expBv)
         expBus = link.busData;
      if (expDv)
         expDbg = link.debugData;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         nErrors++;
         giveVerdict();
      end
   end
   task automatic giveVerdict();
      if (nErrors == 0 && nChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : giveVerdict
   task automatic chkVec(input logic [3:0] got, input logic [3:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chkVec
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chkWord
   task automatic chkInv(input logic [3:0] exp);
      logic [3:0] acc;
      acc = 4'h0;
      foreach (invQ[i]) acc = acc | invQ[i];
      chkVec(acc, exp);
      chkVec(4'(invQ.size()), 4'($countones(exp)));
   endtask : chkInv
   task automatic settle();
      repeat (40) @(negedge clk);
   endtask : settle
   task automatic drive(input logic [9:0] c);
      @(negedge clk);
      {powerOnReq, primaryReq, sharedReq, selftestReq} = c;
      {normal_interrupt_n, fIrq, vnIrq, vfIrq} = 16'($random(seed));
      {dEn, sEn, dRq} = 12'($random(seed));
      settle();
   endtask : drive
   task automatic checkAll();
      logic [3:0] po, st, off, dbg;
      po = ~(powerOnReq | primaryReq | debugReq);
      dbg = ~debugReq;
      st = selftestReq ? 4'h0 : 4'hf;
      off = (po == 4'h0 && sharedReq
             && !(primaryReq == 4'hf && debugReq == 4'h0)) ? 4'h0 : 4'hf;
      chkVec(coreRst, po & ~primaryReq & st);
      chkVec(coreDbgRst, po & dbg & st & off);
      chkVec(dbgDomRst, dbg & st & off);
      chkVec({3'h0, sharedOut}, {3'h0, !(sharedReq | selftestReq)});
      chkVec({3'h0, selftestPrepare}, {3'h0, selftestReq});
      chkVec(oN, selftestReq ? 4'hf : ~normal_interrupt_n);
      chkWord({20'h0, oF, oVn, oVf},
         {20'h0, selftestReq ? 12'hfff : ~{fIrq, vnIrq, vfIrq}});
      chkWord({20'h0, oDe, oSe, oDr},
         {20'h0, selftestReq ? 12'h0 : {dEn, sEn, dRq}});
   endtask : checkAll
   initial
   begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      settle();
      checkAll();
      foreach (combos[i])
      begin
         drive(combos[i]);
         checkAll();
      end
      for (int n = 0; n < 4; n++)
      begin
         k = {$random(seed)} % 3;
         skip = 4'($random(seed));
         drive(10'h0);
         @(negedge clk);
         powerOnReq = (k == 0) ? 4'h1 << n : 4'h0;
         primaryReq = (k == 1) ? 4'h1 << n : 4'h0;
         debugReq = (k == 2) ? 4'h1 << n : 4'h0;
         settle();
         checkAll();
         invQ.delete();
         drive(10'h0);
         debugReq = 4'h0;
         settle();
         checkAll();
         chkInv((4'h1 << n) & ~skip);
      end
      foreach (ratios[i])
      begin
         @(negedge clk);
         busRatioReq = 4'(ratios[i]);
         debugRatioReq = 4'(ratios[(i + 1) % 5]);
         ratioLoad = 1'b1;
         @(negedge clk);
         ratioLoad = 1'b0;
         chkVec({3'h0, ratioBusy}, 4'h1);
         @(negedge clk);
         ratioLoad = 1'b1;
         busRatioReq = 4'h7;
         @(negedge clk);
         ratioLoad = 1'b0;
         for (k = 0; k < 100 && ratioBusy !== 1'b0; k++)
            @(negedge clk);
         chkVec({3'h0, ratioBusy}, 4'h0);
         repeat (400) @(negedge clk);
         chkVec(busRatio, ratios[i] == 0 ? 4'h1 : 4'(ratios[i]));
         k = ratios[(i + 1) % 5];
         chkVec(debugRatio, k == 0 ? 4'h1 : 4'(k));
      end
      giveVerdict();
   end
endmodule : multicore_reset_clock_enable_ctrl_tb_top
`default_nettype wire
